// ==== rtl/smbs_regs.vh ====
// register map, field positions, reset values and timing for smbs_ctrl
// assumes a byte-wide register port indexed by a 4-bit address
`ifndef SMBS_REGS_VH
`define SMBS_REGS_VH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define SMBS_CTRL_IDX    4'h0
`define SMBS_CFG_IDX     4'h1
`define SMBS_DATA_IDX    4'h2
`define SMBS_ADR_IDX     4'h3
`define SMBS_ADM_IDX     4'h4
`define SMBS_ISTAT_IDX   4'h5
`define SMBS_ICLR_IDX    4'h6
`define SMBS_IEN_IDX     4'h7
`define SMBS_DIV_IDX     4'h8

// ----------------------------------------------------------------------
// bus_control_reg fields, status vector in [7:4]
// ----------------------------------------------------------------------
`define SMBS_SI_BIT      0
`define SMBS_ACK_BIT     1
`define SMBS_ARBL_BIT    2
`define SMBS_ACK_REQUEST_FLAG_BIT   3
`define SMBS_STO_BIT     4
`define SMBS_STA_BIT     5
`define SMBS_TXM_BIT     6
`define SMBS_MST_BIT     7

// ----------------------------------------------------------------------
// config fields and interrupt status bits
// ----------------------------------------------------------------------
`define SMBS_EN_BIT      0
`define SMBS_INH_BIT     1
`define SMBS_HWACK_BIT   2
`define SMBS_EV_BYTE     0
`define SMBS_EV_STOP     1
`define SMBS_EV_ARB      2
`define SMBS_EV_ERR      3

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define SMBS_CFG_RST     3'h0
`define SMBS_ADR_RST     8'h00
`define SMBS_ADM_RST     8'hFE
`define SMBS_IEN_RST     4'h0
`define SMBS_CLK_MHZ     125
`define SMBS_SCL_HALF_NS 5000
`define SMBS_SCL_HALF_CYC (`SMBS_SCL_HALF_NS * `SMBS_CLK_MHZ / 1000)
`define SMBS_DIV_RST     ((`SMBS_SCL_HALF_CYC / 4) - 1)

`endif

// ==== rtl/smbs_ctrl.v ====
// two-wire serial controller: slave read/write, master, status vector
// assumes open-drain pins resolved outside; scl/sda arrive asynchronously
//
// What this block does
// [RULE1] inhibit clear: address byte puts slave in receiver
// [RULE2] no hw ack: address raises interrupt, ack request
// [RULE3] hw ack: matching address acked, interrupt after ack
// [RULE4] nacked address mutes slave until next start
// [RULE5] acked read address: shift out loaded bytes
// [RULE6] master acks each byte; nack ends reading
// [RULE7] data write after nack flags an error
// [RULE8] stop condition ends slave transmitter mode
// [RULE9] clear without data write: back to receiver
// [RULE10] transmitter interrupt always after the ack cycle
// [RULE11] status vector: master, tx, start, stop
// [RULE12] generated start reports 1110 and waits
// [RULE13] nack in 1100: start restarts, stop aborts
// [RULE14] ack in 1100: data, stop, both, or restart
// [RULE15] clear without data: master receiver, status 1000
// [RULE16] ack bit 1 sends ack, 0 sends nack
// [RULE17] master from own start until stop or loss
// [RULE18] clock held low while interrupt flag set
//
// Our own choices: the address map and the plain strobed port.
`include "smbs_regs.vh"
module smbs_ctrl (
  input  wire       core_clk,   // system clock
  input  wire       srst,       // synchronous reset, active high
  input  wire [3:0] reg_addr,   // register index
  input  wire [7:0] reg_wdata,  // write data
  input  wire       reg_we,     // write strobe
  input  wire       reg_re,     // read strobe
  output reg  [7:0] reg_rdata,  // read data, cycle after reg_re
  output reg        irq,        // level interrupt
  input  wire       scl_in,     // clock line level
  output wire       scl_out,    // clock line drive value
  output wire       scl_oe_n,   // clock line pulled low when 0
  input  wire       sda_in,     // data line level
  output wire       sda_out,    // data line drive value
  output wire       sda_oe_n    // data line pulled low when 0
);

  localparam [2:0] MG_IDLE  = 3'h0;
  localparam [2:0] MG_START = 3'h1;
  localparam [2:0] MG_RUN   = 3'h2;
  localparam [2:0] MG_STOP  = 3'h3;
  localparam [2:0] MG_RSTA  = 3'h4;
  localparam [31:0] DIV_RST = `SMBS_DIV_RST;

  // --------------------------------------------------------------------
  // pin synchronisers and bus condition detection
  // --------------------------------------------------------------------
  reg  [1:0] scl_sy_q;
  reg  [1:0] sda_sy_q;
  reg        scl_d1_q;
  reg        sda_d1_q;

  always @(posedge core_clk) begin
    if (srst) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_in};
      sda_sy_q <= {sda_sy_q[0], sda_in};
      scl_d1_q <= scl_sy_q[1];
      sda_d1_q <= sda_sy_q[1];
    end
  end

  wire scl_s     = scl_sy_q[1];
  wire sda_s     = sda_sy_q[1];
  wire scl_rise  = scl_s & ~scl_d1_q;
  wire scl_fall  = ~scl_s & scl_d1_q;
  wire start_det = scl_s & scl_d1_q & ~sda_s & sda_d1_q;
  wire stop_det  = scl_s & scl_d1_q & sda_s & ~sda_d1_q;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  reg  [2:0] cfg_q;
  reg  [7:0] sadr_q;
  reg  [7:0] sadm_q;
  reg  [7:0] div_q;
  reg  [3:0] ien_q;
  reg  [3:0] stat_q;
  reg  [9:0] div_cnt_q;
  reg  [7:0] shreg_q;
  reg  [3:0] cnt_q;
  reg  [2:0] mg_q;
  reg        step_q;
  reg        master_q;
  reg        transmit_direction_flag_q;
  reg        sta_q;
  reg        sto_q;
  reg        si_q;
  reg        ack_request_flag_q;
  reg        arbl_q;
  reg        ack_q;
  reg        addr_ph_q;
  reg        rd_q;
  reg        mute_q;
  reg        busy_q;
  reg        slv_q;
  reg        data_wr_q;
  reg        scl_low_q;
  reg        sda_low_q;
  reg        si_prev_q;
  reg        arb_prev_q;

  wire en    = cfg_q[`SMBS_EN_BIT];
  wire slave_event_inhibit   = cfg_q[`SMBS_INH_BIT];
  wire hwack = cfg_q[`SMBS_HWACK_BIT];
  wire tick  = (div_cnt_q == {div_q, 2'h3});

  wire wr_ctrl = reg_we & (reg_addr == `SMBS_CTRL_IDX);
  wire wr_data = reg_we & (reg_addr == `SMBS_DATA_IDX);
  wire wr_iclr = reg_we & (reg_addr == `SMBS_ICLR_IDX);
  wire si_clr  = wr_ctrl & si_q & ~reg_wdata[`SMBS_SI_BIT];
  wire sta_n   = reg_wdata[`SMBS_STA_BIT];
  wire sto_n   = reg_wdata[`SMBS_STO_BIT];
  wire ack_n   = reg_wdata[`SMBS_ACK_BIT];
  // a nack was just taken as slave transmitter: loading data is an error
  wire data_err = wr_data & si_q & transmit_direction_flag_q & ~master_q & ~ack_q;
  wire adr_hit = (((shreg_q[7:1] ^ sadr_q[7:1]) & sadm_q[7:1]) == 7'h00);
  // a disabled controller, or a muted or inhibited slave, ignores the bit stream
  wire active  = en & (master_q | slv_q | (addr_ph_q & ~mute_q & ~slave_event_inhibit));

  // held low while the flag is up so the far master waits
  assign scl_oe_n = ~(si_q | scl_low_q);  // see [RULE18]
  assign scl_out  = 1'b0;
  assign sda_oe_n = ~sda_low_q;
  assign sda_out  = 1'b0;

  // --------------------------------------------------------------------
  // bit rate divider
  // --------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst)
      div_cnt_q <= 10'h000;
    else if (tick)
      div_cnt_q <= 10'h000;
    else
      div_cnt_q <= div_cnt_q + 10'h001;
  end

  // --------------------------------------------------------------------
  // serial engine and master sequencer
  // --------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      shreg_q   <= 8'h00;
      cnt_q     <= 4'h0;
      mg_q      <= MG_IDLE;
      step_q    <= 1'b0;
      master_q  <= 1'b0;
      transmit_direction_flag_q  <= 1'b0;
      sta_q     <= 1'b0;
      sto_q     <= 1'b0;
      si_q      <= 1'b0;
      ack_request_flag_q   <= 1'b0;
      arbl_q    <= 1'b0;
      ack_q     <= 1'b0;
      addr_ph_q <= 1'b0;
      rd_q      <= 1'b0;
      mute_q    <= 1'b0;
      busy_q    <= 1'b0;
      slv_q     <= 1'b0;
      data_wr_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      if (wr_data & ~data_err) begin
        shreg_q   <= reg_wdata;
        data_wr_q <= 1'b1;
      end
      if (wr_ctrl) begin
        sta_q <= sta_n;
        sto_q <= sto_n;
        ack_q <= ack_n;
      end

      // bus conditions and bit edges
      if (start_det) begin
        busy_q    <= 1'b1;
        cnt_q     <= 4'h0;
        addr_ph_q <= 1'b1;
        mute_q    <= 1'b0;               // see [RULE4]
        slv_q     <= 1'b0;
        transmit_direction_flag_q  <= master_q;
      end else if (stop_det) begin
        busy_q    <= 1'b0;
        cnt_q     <= 4'h0;
        addr_ph_q <= 1'b0;
        slv_q     <= 1'b0;
        transmit_direction_flag_q  <= 1'b0;               // see [RULE8]
      end else if (scl_rise & active) begin
        if (cnt_q < 4'h8) begin
          shreg_q <= {shreg_q[6:0], sda_s};
          cnt_q   <= cnt_q + 4'h1;
          if (master_q & transmit_direction_flag_q & shreg_q[7] & ~sda_s) begin
            master_q  <= 1'b0;           // see [RULE17]
            transmit_direction_flag_q  <= 1'b0;
            arbl_q    <= 1'b1;
            si_q      <= 1'b1;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            mg_q      <= MG_IDLE;
          end
        end else begin
          if (transmit_direction_flag_q)
            ack_q <= ~sda_s;             // see [RULE6]
          cnt_q <= 4'h9;
        end
      end else if (scl_fall & active) begin
        if (cnt_q < 4'h8) begin
          sda_low_q <= transmit_direction_flag_q & ~shreg_q[7];
        end else if (cnt_q == 4'h8) begin
          if (transmit_direction_flag_q) begin
            sda_low_q <= 1'b0;
          end else if (addr_ph_q & ~master_q) begin
            rd_q <= shreg_q[0];          // see [RULE1]
            if (hwack) begin
              if (adr_hit) begin
                sda_low_q <= 1'b1;       // see [RULE3]
              end else begin
                mute_q    <= 1'b1;       // see [RULE4]
                addr_ph_q <= 1'b0;
                sda_low_q <= 1'b0;
              end
            end else begin
              si_q    <= 1'b1;           // see [RULE2]
              ack_request_flag_q <= 1'b1;
              sta_q   <= 1'b1;
            end
          end else if (hwack) begin
            sda_low_q <= ack_q;          // see [RULE16]
          end else begin
            si_q    <= 1'b1;
            ack_request_flag_q <= 1'b1;
          end
        end else begin
          cnt_q     <= 4'h0;
          sda_low_q <= 1'b0;
          if (addr_ph_q & ~master_q) begin
            addr_ph_q <= 1'b0;
            if (sda_low_q) begin
              slv_q    <= 1'b1;
              transmit_direction_flag_q <= rd_q;          // see [RULE5]
              // an acked address is no nack: first data load is legal
              ack_q    <= 1'b1;          // see [RULE7]
              if (hwack) begin
                si_q  <= 1'b1;           // see [RULE3]
                sta_q <= 1'b1;
              end else if (rd_q) begin
                sda_low_q <= ~shreg_q[7];
              end
            end else begin
              mute_q <= 1'b1;            // see [RULE4]
            end
          end else begin
            addr_ph_q <= 1'b0;
            if (transmit_direction_flag_q | hwack)
              si_q <= 1'b1;              // see [RULE10]
          end
        end
      end

      // software releases the held clock
      if (si_clr) begin
        si_q      <= 1'b0;
        ack_request_flag_q   <= 1'b0;
        arbl_q    <= 1'b0;
        data_wr_q <= 1'b0;
        if (master_q) begin
          if (sto_n) begin
            sda_low_q <= 1'b1;           // see [RULE13] [RULE14]
            step_q    <= 1'b0;
            mg_q      <= MG_STOP;
          end else if (sta_n) begin
            sda_low_q <= 1'b0;           // see [RULE13] [RULE14]
            step_q    <= 1'b0;
            mg_q      <= MG_RSTA;
          end else if (cnt_q == 4'h8 & ~transmit_direction_flag_q) begin
            sda_low_q <= ack_n;          // see [RULE16]
          end else if (data_wr_q) begin
            transmit_direction_flag_q  <= 1'b1;           // see [RULE14]
            sda_low_q <= ~shreg_q[7];
          end else begin
            transmit_direction_flag_q  <= 1'b0;           // see [RULE15]
            sda_low_q <= 1'b0;
          end
        end else begin
          sta_q <= 1'b0;
          if (cnt_q == 4'h8) begin
            sda_low_q <= ack_n;          // see [RULE16]
            if (~ack_n & addr_ph_q)
              mute_q <= 1'b1;            // see [RULE4]
          end else if (transmit_direction_flag_q) begin
            if (data_wr_q) begin
              sda_low_q <= ~shreg_q[7];  // see [RULE5]
            end else begin
              transmit_direction_flag_q  <= 1'b0;         // see [RULE9]
              sda_low_q <= 1'b0;
            end
          end
        end
      end

      // master clock and condition generation on divider ticks, except the first start pull from MG_IDLE
      case (mg_q)
        MG_IDLE: begin
          if (en & sta_q & ~busy_q & ~si_q & ~wr_ctrl) begin
            sda_low_q <= 1'b1;
            mg_q      <= MG_START;
          end
        end
        MG_START: begin
          if (tick) begin
            scl_low_q <= 1'b1;
            master_q  <= 1'b1;           // see [RULE17]
            transmit_direction_flag_q  <= 1'b1;
            si_q      <= 1'b1;           // see [RULE12]
            data_wr_q <= 1'b0;
            mg_q      <= MG_RUN;
          end
        end
        MG_RUN: begin
          // a released clock held low by the far end stretches the bit
          if (tick & ~si_q) begin
            if (scl_low_q)
              scl_low_q <= 1'b0;
            else if (scl_s)
              scl_low_q <= 1'b1;
          end
        end
        MG_STOP: begin
          if (tick) begin
            if (~step_q) begin
              scl_low_q <= 1'b0;
              step_q    <= 1'b1;
            end else if (scl_s) begin
              sda_low_q <= 1'b0;
              master_q  <= 1'b0;         // see [RULE17]
              transmit_direction_flag_q  <= 1'b0;
              sto_q     <= 1'b0;
              mg_q      <= MG_IDLE;
            end
          end
        end
        MG_RSTA: begin
          if (tick) begin
            if (~step_q) begin
              scl_low_q <= 1'b0;
              step_q    <= 1'b1;
            end else if (scl_s) begin
              sda_low_q <= 1'b1;
              mg_q      <= MG_START;
            end
          end
        end
        default: mg_q <= MG_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // register port and interrupt
  // --------------------------------------------------------------------
  wire [3:0] ev;
  assign ev[`SMBS_EV_BYTE] = si_q & ~si_prev_q;
  assign ev[`SMBS_EV_STOP] = stop_det;
  assign ev[`SMBS_EV_ARB]  = arbl_q & ~arb_prev_q;
  assign ev[`SMBS_EV_ERR]  = data_err;   // see [RULE7]

  wire [3:0] iclr = wr_iclr ? reg_wdata[3:0] : 4'h0;
  wire [7:0] ctrl_rd = {master_q, transmit_direction_flag_q, sta_q, sto_q,
                        ack_request_flag_q, arbl_q, ack_q, si_q};

  always @(posedge core_clk) begin
    if (srst) begin
      cfg_q      <= `SMBS_CFG_RST;
      sadr_q     <= `SMBS_ADR_RST;
      sadm_q     <= `SMBS_ADM_RST;
      div_q      <= DIV_RST[7:0];
      ien_q      <= `SMBS_IEN_RST;
      stat_q     <= 4'h0;
      si_prev_q  <= 1'b0;
      arb_prev_q <= 1'b0;
      irq        <= 1'b0;
      reg_rdata  <= 8'h00;
    end else begin
      si_prev_q  <= si_q;
      arb_prev_q <= arbl_q;
      if (reg_we) begin
        case (reg_addr)
          `SMBS_CFG_IDX: cfg_q  <= reg_wdata[2:0];
          `SMBS_ADR_IDX: sadr_q <= reg_wdata;
          `SMBS_ADM_IDX: sadm_q <= reg_wdata;
          `SMBS_IEN_IDX: ien_q  <= reg_wdata[3:0];
          `SMBS_DIV_IDX: div_q  <= reg_wdata;
          default: ;
        endcase
      end
      // a new event beats a clear in the same cycle
      stat_q <= (stat_q & ~iclr) | ev;
      irq    <= |(stat_q & ien_q);
      reg_rdata <= 8'h00;
      if (reg_re) begin
        case (reg_addr)
          `SMBS_CTRL_IDX:  reg_rdata <= ctrl_rd;  // see [RULE11]
          `SMBS_CFG_IDX:   reg_rdata <= {5'h00, cfg_q};
          `SMBS_DATA_IDX:  reg_rdata <= shreg_q;
          `SMBS_ADR_IDX:   reg_rdata <= sadr_q;
          `SMBS_ADM_IDX:   reg_rdata <= sadm_q;
          `SMBS_ISTAT_IDX: reg_rdata <= {4'h0, stat_q};
          `SMBS_IEN_IDX:   reg_rdata <= {4'h0, ien_q};
          `SMBS_DIV_IDX:   reg_rdata <= div_q;
          default:         reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ==== verification/smbs_ctrl_checker.sv ====
// port assertions for smbs_ctrl
// assumes one clock domain with a synchronous reset
`include "smbs_regs.vh"
module smbs_ctrl_checker (
  input logic       core_clk,   // clock
  input logic       srst,       // reset
  input logic [3:0] reg_addr,   // index
  input logic [7:0] reg_wdata,  // write data
  input logic       reg_we,     // write strobe
  input logic       reg_re,     // read strobe
  input logic [7:0] reg_rdata,  // read data
  input logic       irq,        // interrupt
  input logic       scl_in,     // clock line
  input logic       scl_out,    // clock drive
  input logic       scl_oe_n,   // clock pull
  input logic       sda_in,     // data line
  input logic       sda_out,    // data drive
  input logic       sda_oe_n    // data pull
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_ctrl_read;
    reg_re && reg_addr == `SMBS_CTRL_IDX;
  endsequence
  sequence s_si_seen;
    s_ctrl_read ##1 reg_rdata[`SMBS_SI_BIT];
  endsequence
  a_rdata_idle: assert property (!reg_re |=> reg_rdata == 8'h00)
    else $error("read data not cleared");
  a_unmapped_read: assert property (
    reg_re && reg_addr > `SMBS_DIV_IDX |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_istat_width: assert property (
    reg_re && reg_addr == `SMBS_ISTAT_IDX |=> reg_rdata[7:4] == 4'h0)
    else $error("status upper bits set");
  a_pins_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  a_reset_quiet: assert property (
    $fell(srst) |-> scl_oe_n && sda_oe_n && !irq && reg_rdata == 8'h00)
    else $error("outputs active after reset");
  a_ien_mask: assert property (
    reg_we && reg_addr == `SMBS_IEN_IDX && reg_wdata[3:0] == 4'h0 |=>
    !(reg_we && reg_addr == `SMBS_IEN_IDX) |=> !irq)
    else $error("masked interrupt still high");
  a_si_stretch: assert property (s_si_seen |-> !scl_oe_n)
    else $error("clock released while flag set");
  a_si_holds: assert property (
    s_si_seen ##0 !reg_we [*3] |-> !scl_oe_n)
    else $error("clock released before flag cleared");
endmodule
bind smbs_ctrl smbs_ctrl_checker smbs_ctrl_checker_i (
  .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .irq(irq), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// ==== verification/smbs_master_model.sv ====
// two-wire bus master model, open drain, 80 ns bit period
// assumes pull-ups on both resolved lines in the bench
module smbs_master_model (
  input  logic scl,       // resolved clock line
  input  logic sda,       // resolved data line
  output logic scl_oe_n,  // 0 pulls clock low
  output logic sda_oe_n   // 0 pulls data low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 20;
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // data moves halfway into the low phase, clear of the falling edge
  task automatic clk_bit(input logic d, output logic s);
    #Q sda_oe_n = d;
    #Q scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #Q s = sda;
    #Q scl_oe_n = 1'b0;
  endtask
  task automatic start();
    #(2*Q) sda_oe_n = 1'b0;
    #(2*Q) scl_oe_n = 1'b0;
  endtask
  task automatic stop();
    #Q sda_oe_n = 1'b0;
    #Q scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #(2*Q) sda_oe_n = 1'b1;
    #(2*Q);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, nack);
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, b[i]);
    clk_bit(nack, s);
  endtask
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for smbs_ctrl with a bus master model
// assumes pull-ups on both lines, resolved here
`include "smbs_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] v;
  } smbs_row_t;
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_we = 1'b0;
  logic       reg_re = 1'b0;
  wire  [7:0] reg_rdata;
  wire        irq, scl_out, sda_out, d_scl, d_sda, m_scl, m_sda;
  wire        scl = d_scl & m_scl;
  wire        sda = d_sda & m_sda;
  int         n_mismatch = 0;
  int         checked = 0;
  logic [7:0] rv, rx;
  logic       nk;
  logic [7:0] tx [2] = '{8'hA5, 8'h3C};
  smbs_row_t  rows [7] = '{
    '{`SMBS_CFG_IDX, 8'h00}, '{`SMBS_ADR_IDX, `SMBS_ADR_RST},
    '{`SMBS_ADM_IDX, `SMBS_ADM_RST}, '{`SMBS_IEN_IDX, 8'h00},
    '{`SMBS_ISTAT_IDX, 8'h00}, '{`SMBS_DIV_IDX, 8'(`SMBS_DIV_RST)},
    '{4'hF, 8'h00}};
  always #4 core_clk = ~core_clk;
  smbs_ctrl smbs_ctrl_i (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .irq(irq), .scl_in(scl),
    .scl_out(scl_out), .scl_oe_n(d_scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(d_sda));
  smbs_master_model smbs_master_model_i (
    .scl(scl), .sda(sda), .scl_oe_n(m_scl), .sda_oe_n(m_sda));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // polls the control register; a poll that runs out is a mismatch
  task automatic wait_ctrl(input logic [7:0] m, input logic [7:0] v);
    for (int i = 0; i < 3000; i++) begin
      rd(`SMBS_CTRL_IDX, rv);
      if ((rv & m) === v)
        break;
    end
    chk(rv & m, v);
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h0, irq}, {7'h0, v});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, rv);
      chk(rv, rows[i].v);
    end
    wr(`SMBS_ADR_IDX, 8'h84);
    wr(`SMBS_IEN_IDX, 8'h01);
    wr(`SMBS_CFG_IDX, 8'h07);
    smbs_master_model_i.start();
    smbs_master_model_i.send_byte(8'h85, nk);
    chk({7'h0, nk}, 8'h01);
    smbs_master_model_i.stop();
    wr(`SMBS_CFG_IDX, 8'h05);
    smbs_master_model_i.start();
    smbs_master_model_i.send_byte(8'h85, nk);
    chk({7'h0, nk}, 8'h00);
    wait_ctrl(8'hF1, 8'h61);
    // irq trails the flag by two registered stages
    irq_is(1'b1);
    chk({7'h0, d_scl}, 8'h00);
    foreach (tx[i]) begin
      fork
        smbs_master_model_i.recv_byte(i == 1, rx);
        begin
          wr(`SMBS_DATA_IDX, tx[i]);
          wr(`SMBS_CTRL_IDX, 8'h00);
        end
      join
      chk(rx, tx[i]);
      wait_ctrl(8'hF3, i ? 8'h41 : 8'h43);
    end
    rd(`SMBS_ISTAT_IDX, rv);
    chk(rv & 8'h08, 8'h00);
    wr(`SMBS_DATA_IDX, 8'hFF);
    wr(`SMBS_CTRL_IDX, 8'h00);
    rd(`SMBS_ISTAT_IDX, rv);
    chk(rv & 8'h08, 8'h08);
    rd(`SMBS_CTRL_IDX, rv);
    chk(rv & 8'h40, 8'h00);
    wr(`SMBS_IEN_IDX, 8'h00);
    irq_is(1'b0);
    wr(`SMBS_IEN_IDX, 8'h0F);
    irq_is(1'b1);
    wr(`SMBS_ICLR_IDX, 8'h0F);
    irq_is(1'b0);
    smbs_master_model_i.stop();
    wait_ctrl(8'hF0, 8'h00);
    // a transmitter still armed when the stop arrives
    smbs_master_model_i.start();
    smbs_master_model_i.send_byte(8'h85, nk);
    wait_ctrl(8'hF1, 8'h61);
    wr(`SMBS_DATA_IDX, 8'hFF);
    wr(`SMBS_CTRL_IDX, 8'h00);
    rd(`SMBS_CTRL_IDX, rv);
    chk(rv & 8'hF1, 8'h40);
    smbs_master_model_i.stop();
    wait_ctrl(8'hF0, 8'h00);
    wr(`SMBS_CFG_IDX, 8'h01);
    smbs_master_model_i.start();
    fork
      smbs_master_model_i.send_byte(8'h85, nk);
      begin
        wait_ctrl(8'h09, 8'h09);
        wr(`SMBS_CTRL_IDX, 8'h00);
      end
    join
    chk({7'h0, nk}, 8'h01);
    smbs_master_model_i.send_byte(8'h85, nk);
    chk({7'h0, nk}, 8'h01);
    rd(`SMBS_CTRL_IDX, rv);
    chk(rv & 8'h01, 8'h00);
    smbs_master_model_i.stop();
    wr(`SMBS_DIV_IDX, 8'h03);
    wr(`SMBS_CTRL_IDX, 8'h20);
    wait_ctrl(8'hF1, 8'hE1);
    wr(`SMBS_DATA_IDX, 8'hB0);
    wr(`SMBS_CTRL_IDX, 8'h00);
    wait_ctrl(8'hF3, 8'hC1);
    wr(`SMBS_CTRL_IDX, 8'h20);
    wait_ctrl(8'hF1, 8'hE1);
    wr(`SMBS_CTRL_IDX, 8'h00);
    wait_ctrl(8'hF9, 8'h89);
    wr(`SMBS_CTRL_IDX, 8'h10);
    wait_ctrl(8'h80, 8'h00);
    tally_and_finish();
  end
endmodule
